// ### design/lcdso_pkg.sv
// Constants shared by the segment output block and its helpers.
// Assumes a serial frame of address, display bits and configuration bits.
package lcdso_pkg;
   // Serial link framing.
   localparam logic [7:0] LCDSO_DEV_ADDR = 8'h44;
   localparam int LCDSO_ADDR_BITS = 8;
   localparam int LCDSO_DISP_BITS = 78;
   localparam int LCDSO_FRAME_BITS = 110;
   // Field positions inside a received frame.
   localparam int LCDSO_POS_DUTY_LO = 78;
   localparam int LCDSO_POS_DUTY_HI = 79;
   localparam int LCDSO_POS_EXT_EN = 80;
   localparam int LCDSO_POS_PSEL = 81;
   localparam int LCDSO_POS_FUNC = 84;
   localparam int LCDSO_POS_PWM = 92;
   localparam int LCDSO_PWM_W = 6;
   localparam int LCDSO_PWM_CH = 3;
   localparam int LCDSO_EXTRA_SEG_BITS = 6;
   // Port function codes, high bit then low bit.
   localparam logic [1:0] LCDSO_FN_LEVEL = 2'h0;
   localparam logic [1:0] LCDSO_FN_CLOCK = 2'h1;
   // Register offsets.
   localparam logic [7:0] LCDSO_REG_SCAN_DIV = 8'h00;
   localparam logic [7:0] LCDSO_REG_PWM_DIV = 8'h04;
   localparam logic [7:0] LCDSO_REG_EXTRA_SEG = 8'h08;
   localparam logic [7:0] LCDSO_REG_STATUS = 8'h0C;
   localparam logic [7:0] LCDSO_REG_PORT_CFG = 8'h10;
   localparam logic [7:0] LCDSO_REG_DISP0 = 8'h14;
   localparam logic [7:0] LCDSO_REG_DISP1 = 8'h18;
   localparam logic [7:0] LCDSO_REG_DISP2 = 8'h1C;
   // Reset values and timing counts.
   localparam logic [15:0] LCDSO_SCAN_DIV_RST = 16'h0400;
   localparam logic [15:0] LCDSO_PWM_DIV_RST = 16'h0010;
   localparam logic [7:0] LCDSO_CLK_OUT_DIV = 8'h40;
   typedef enum logic [1:0] {LCDSO_QUARTER, LCDSO_THIRD, LCDSO_HALF, LCDSO_STATIC} lcdso_duty_t;
endpackage

// ### design/lcdso_serial_rx.sv
// Serial receiver for address, display and configuration bits.
// Runs on the serial clock; the frame is held until the next full frame.
`timescale 1ns/1ps
module lcdso_serial_rx
   import lcdso_pkg::*;
(
   // Link side.
   input wire logic serial_clock,
   input wire logic presetn,
   input wire logic chip_enable,
   input wire logic serial_data_in,
   // Captured frame.
   output logic [LCDSO_FRAME_BITS-1:0] frame_ff,
   output logic frame_tgl_ff
);
   logic [LCDSO_ADDR_BITS-1:0] addr_sr_ff;
   logic [LCDSO_FRAME_BITS-1:0] data_sr_ff;
   logic [7:0] cnt_ff;
   wire logic addr_ok;
   wire logic last_bit;

   assign addr_ok = (addr_sr_ff == LCDSO_DEV_ADDR);
   assign last_bit = (cnt_ff == 8'(LCDSO_FRAME_BITS - 1));

   always_ff @(posedge serial_clock or negedge presetn) begin
      if (!presetn) begin
         addr_sr_ff <= '0;
         data_sr_ff <= '0;
         cnt_ff <= 8'h00;
      end else if (!chip_enable) begin
         addr_sr_ff <= {serial_data_in, addr_sr_ff[LCDSO_ADDR_BITS-1:1]};
         cnt_ff <= 8'h00;
      end else if (addr_ok && cnt_ff < 8'(LCDSO_FRAME_BITS)) begin
         data_sr_ff <= {serial_data_in, data_sr_ff[LCDSO_FRAME_BITS-1:1]};
         cnt_ff <= cnt_ff + 8'h01;
      end
   end

   always_ff @(posedge serial_clock or negedge presetn) begin
      if (!presetn) begin
         frame_ff <= '0;
         frame_tgl_ff <= 1'b0;
      end else if (chip_enable && addr_ok && last_bit) begin
         frame_ff <= {serial_data_in, data_sr_ff[LCDSO_FRAME_BITS-1:1]};
         frame_tgl_ff <= ~frame_tgl_ff;
      end
   end
endmodule

// ### design/lcdso_pwm.sv
// Three channel pulse width generator with a shared 64 step period.
// Assumes widths are stable copies held in the same clock domain.
`timescale 1ns/1ps
module lcdso_pwm #(
   parameter int W = 6,
   parameter int CH = 3
) (
   // Clock and reset.
   input wire logic pclk,
   input wire logic presetn,
   // Settings.
   input wire logic [15:0] step_div,
   input wire logic [CH*W-1:0] width,
   // Channel outputs.
   output logic [CH-1:0] pwm_ff
);
   logic [15:0] div_ff;
   logic [W-1:0] cnt_ff;
   wire logic step;

   assign step = (div_ff >= step_div);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         div_ff <= 16'h0000;
         cnt_ff <= '0;
      end else if (step) begin
         div_ff <= 16'h0000;
         cnt_ff <= cnt_ff + W'(1);
      end else begin
         div_ff <= div_ff + 16'h0001;
      end
   end

   for (genvar c = 0; c < CH; c++) begin : g_ch
      always_ff @(posedge pclk or negedge presetn) begin
         if (!presetn) begin
            pwm_ff[c] <= 1'b0;
         end else begin
            pwm_ff[c] <= (cnt_ff <= width[c*W +: W]);
         end
      end
   end

   property p_full_width;
      @(posedge pclk) disable iff (!presetn)
      (width[CH*W-1 -: W] == '1) [*2] |-> pwm_ff[CH-1];
   endproperty
   a_full_width: assert property (p_full_width) else $error("Full width channel went low.");
endmodule

// ### design/lcdso_top.sv
// Segment LCD output configuration: scan drive, port functions, inhibit.
// Assumes a serial controller on its own clock and an APB master on pclk.
//
// How it works
// - Duty bits 00 give quarter duty, third bias, four commons.
// - Duty bits lo=1 hi=0 give third duty, third bias, common four becomes segment 25.
// - Duty bits lo=0 hi=1 give half duty, half bias, commons three and four become segments 26 and 25.
// - Duty bits 11 give static drive, commons two to four become segments 27, 26 and 25.
// - Extra segment 28 sits at ground when disabled and is a normal segment when enabled.
// - In third duty segment n takes display bits 3n-2 to 3n, segment 25 bits 73-75, segment 28 bits 76-78.
// - The port count field turns zero to four shared pins into ports; codes above four keep all segments.
// - A level port drives the first display bit of its pin, bits 1, 4, 7 and 10.
// - Port one chooses between level, clock and pulse width output.
// - Ports two to four choose only between level and pulse width output.
// - Three pulse width channels each have their own six bit width.
// - A low inhibit pin forces every display output to ground; half_bias_out is not gated by it.
`timescale 1ns/1ps
module lcdso_top
   import lcdso_pkg::*;
#(
   parameter logic [15:0] SCAN_DIV_RST = LCDSO_SCAN_DIV_RST,
   parameter logic [15:0] PWM_DIV_RST = LCDSO_PWM_DIV_RST
) (
   // Clock and reset.
   input wire logic pclk,
   input wire logic presetn,
   // APB slave.
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Serial link and inhibit pin.
   input wire logic serial_clock,
   input wire logic chip_enable,
   input wire logic serial_data_in,
   input wire logic display_inhibit_n,
   // Display outputs.
   output logic common1_out,
   output logic common2_or_seg27,
   output logic common3_or_seg26,
   output logic common4_or_seg25,
   output logic [19:0] segment_mid_out,
   output logic extra_segment_out,
   output logic shared_out_1,
   output logic shared_out_2,
   output logic shared_out_3,
   output logic shared_out_4,
   output logic half_bias_out
);
   localparam int EXT_W = LCDSO_DISP_BITS + LCDSO_EXTRA_SEG_BITS;
   localparam int PWM_BITS = LCDSO_PWM_W * LCDSO_PWM_CH;
   logic [LCDSO_FRAME_BITS-1:0] frame_q;
   logic frame_tgl, ext_en_ff, inv_ff, clk_out_ff;
   logic tgl_s1_ff, tgl_s2_ff, tgl_s3_ff, inh_s1_ff, inh_s2_ff;
   lcdso_duty_t duty_ff;
   logic [1:0] phase_ff;
   logic [2:0] port_sel_ff;
   logic [3:0] shared_ff;
   logic [7:0] func_ff, frames_ff, clk_div_ff;
   logic [15:0] scan_div_ff, pwm_div_ff, div_ff;
   logic [PWM_BITS-1:0] pwm_width_ff;
   logic [LCDSO_DISP_BITS-1:0] disp_ff;
   logic [LCDSO_EXTRA_SEG_BITS-1:0] extra_seg_ff;
   logic [LCDSO_PWM_CH-1:0] pwm;

   // Serial receiver and pulse width generator.
   lcdso_serial_rx u_rx (
      .serial_clock(serial_clock),
      .presetn(presetn),
      .chip_enable(chip_enable),
      .serial_data_in(serial_data_in),
      .frame_ff(frame_q),
      .frame_tgl_ff(frame_tgl)
   );

   lcdso_pwm #(.W(LCDSO_PWM_W), .CH(LCDSO_PWM_CH)) u_pwm (
      .pclk(pclk),
      .presetn(presetn),
      .step_div(pwm_div_ff),
      .width(pwm_width_ff),
      .pwm_ff(pwm)
   );

   // Frame toggle crossing and inhibit synchroniser.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tgl_s1_ff <= 1'b0;
         tgl_s2_ff <= 1'b0;
         tgl_s3_ff <= 1'b0;
         inh_s1_ff <= 1'b0;
         inh_s2_ff <= 1'b0;
      end else begin
         tgl_s1_ff <= frame_tgl;
         tgl_s2_ff <= tgl_s1_ff;
         tgl_s3_ff <= tgl_s2_ff;
         inh_s1_ff <= display_inhibit_n;
         inh_s2_ff <= inh_s1_ff;
      end
   end
   wire logic frame_new = tgl_s2_ff ^ tgl_s3_ff;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         duty_ff <= LCDSO_QUARTER;
         ext_en_ff <= 1'b0;
         port_sel_ff <= 3'h0;
         func_ff <= 8'h00;
         pwm_width_ff <= '0;
         disp_ff <= '0;
         frames_ff <= 8'h00;
      end else if (frame_new) begin
         duty_ff <= lcdso_duty_t'({frame_q[LCDSO_POS_DUTY_HI], frame_q[LCDSO_POS_DUTY_LO]});
         ext_en_ff <= frame_q[LCDSO_POS_EXT_EN];
         port_sel_ff <= {frame_q[LCDSO_POS_PSEL], frame_q[LCDSO_POS_PSEL+1],
                         frame_q[LCDSO_POS_PSEL+2]};
         func_ff <= frame_q[LCDSO_POS_FUNC +: 8];
         pwm_width_ff <= frame_q[LCDSO_POS_PWM +: PWM_BITS];
         disp_ff <= frame_q[LCDSO_DISP_BITS-1:0];
         frames_ff <= frames_ff + 8'h01;
      end
   end

   // APB slave: one wait-free access phase, read data prepared in setup.
   wire logic setup = psel && !penable;
   wire logic wr_go = psel && penable && pready && pwrite;
   wire logic [31:0] status_word = {16'h0000, frames_ff, inv_ff, inh_s2_ff, port_sel_ff,
                                    ext_en_ff, duty_ff};
   wire logic hit = (paddr <= LCDSO_REG_DISP2) && (paddr[1:0] == 2'h0);
   logic [31:0] rd_word;

   always_comb begin
      rd_word = 32'h00000000;
      unique case (paddr)
         LCDSO_REG_SCAN_DIV: rd_word = {16'h0000, scan_div_ff};
         LCDSO_REG_PWM_DIV: rd_word = {16'h0000, pwm_div_ff};
         LCDSO_REG_EXTRA_SEG: rd_word = {26'h0000000, extra_seg_ff};
         LCDSO_REG_STATUS: rd_word = status_word;
         LCDSO_REG_PORT_CFG: rd_word = {6'h00, pwm_width_ff, func_ff};
         LCDSO_REG_DISP0: rd_word = disp_ff[31:0];
         LCDSO_REG_DISP1: rd_word = disp_ff[63:32];
         LCDSO_REG_DISP2: rd_word = {18'h00000, disp_ff[77:64]};
         default: rd_word = 32'h00000000;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h00000000;
      end else begin
         pready <= setup;
         pslverr <= setup && !hit;
         prdata <= (setup && !pwrite) ? rd_word : 32'h00000000;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         scan_div_ff <= SCAN_DIV_RST;
         pwm_div_ff <= PWM_DIV_RST;
         extra_seg_ff <= '0;
      end else if (wr_go) begin
         if (paddr == LCDSO_REG_SCAN_DIV) begin
            scan_div_ff <= pwdata[15:0];
         end
         if (paddr == LCDSO_REG_PWM_DIV) begin
            pwm_div_ff <= pwdata[15:0];
         end
         if (paddr == LCDSO_REG_EXTRA_SEG) begin
            extra_seg_ff <= pwdata[LCDSO_EXTRA_SEG_BITS-1:0];
         end
      end
   end

   // Common scan: the last phase follows from the duty code.
   wire logic [1:0] last_phase = ~duty_ff;
   wire logic phase_step = (div_ff >= scan_div_ff);
   wire logic frame_end = phase_step && (phase_ff >= last_phase);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         div_ff <= 16'h0000;
         phase_ff <= 2'h0;
         inv_ff <= 1'b0;
         clk_div_ff <= 8'h00;
         clk_out_ff <= 1'b0;
      end else begin
         div_ff <= phase_step ? 16'h0000 : div_ff + 16'h0001;
         if (frame_end) begin
            phase_ff <= 2'h0;
            inv_ff <= ~inv_ff;
         end else if (phase_step) begin
            phase_ff <= phase_ff + 2'h1;
         end
         clk_div_ff <= (clk_div_ff == LCDSO_CLK_OUT_DIV) ? 8'h00 : clk_div_ff + 8'h01;
         if (clk_div_ff == LCDSO_CLK_OUT_DIV) begin
            clk_out_ff <= ~clk_out_ff;
         end
      end
   end

   // Segment value for a group of three bits; the fourth phase shows off.
   function automatic logic seg_pick(input logic [EXT_W-1:0] d, input int base,
                                     input logic [1:0] ph, input logic inv);
      logic v;
      v = (ph == 2'h3) ? 1'b0 : d[base + int'(ph)];
      return v ^ inv;
   endfunction

   wire logic [EXT_W-1:0] seg_data = {extra_seg_ff, disp_ff};
   wire logic on = inh_s2_ff;
   wire logic is_quarter = (duty_ff == LCDSO_QUARTER);
   wire logic is_static = (duty_ff == LCDSO_STATIC);
   wire logic is_half = (duty_ff == LCDSO_HALF);

   wire logic com1_v = (phase_ff == 2'h0) ^ inv_ff;
   wire logic com2_v = is_static ? seg_pick(seg_data, 78, phase_ff, inv_ff)
                                 : ((phase_ff == 2'h1) ^ inv_ff);
   wire logic com3_v = (is_static || is_half) ? seg_pick(seg_data, 81, phase_ff, inv_ff)
                                              : ((phase_ff == 2'h2) ^ inv_ff);
   wire logic com4_v = is_quarter ? ((phase_ff == 2'h3) ^ inv_ff)
                                  : seg_pick(seg_data, 72, phase_ff, inv_ff);
   wire logic ext_v = ext_en_ff && seg_pick(seg_data, 75, phase_ff, inv_ff);
   wire logic [2:0] port_cnt = (port_sel_ff <= 3'h4) ? port_sel_ff : 3'h0;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         common1_out <= 1'b0;
         common2_or_seg27 <= 1'b0;
         common3_or_seg26 <= 1'b0;
         common4_or_seg25 <= 1'b0;
         extra_segment_out <= 1'b0;
         half_bias_out <= 1'b0;
      end else begin
         common1_out <= on && com1_v;
         common2_or_seg27 <= on && com2_v;
         common3_or_seg26 <= on && com3_v;
         common4_or_seg25 <= on && com4_v;
         extra_segment_out <= on && ext_v;
         half_bias_out <= is_half;
      end
   end

   for (genvar s = 0; s < 20; s++) begin : g_seg
      always_ff @(posedge pclk or negedge presetn) begin
         if (!presetn) begin
            segment_mid_out[s] <= 1'b0;
         end else begin
            segment_mid_out[s] <= on && seg_pick(seg_data, 12 + 3 * s, phase_ff, inv_ff);
         end
      end
   end

   for (genvar p = 0; p < 4; p++) begin : g_port
      wire logic [1:0] fn = {func_ff[2*p+1], func_ff[2*p]};
      wire logic is_port = (3'(p) < port_cnt);
      logic port_v;
      always_comb begin
         if (fn == LCDSO_FN_LEVEL) begin
            port_v = disp_ff[3*p];
         end else if (p == 0) begin
            port_v = (fn == LCDSO_FN_CLOCK) ? clk_out_ff : pwm[0];
         end else begin
            port_v = pwm[fn - 2'h1];
         end
      end
      always_ff @(posedge pclk or negedge presetn) begin
         if (!presetn) begin
            shared_ff[p] <= 1'b0;
         end else begin
            shared_ff[p] <= on && (is_port ? port_v : seg_pick(seg_data, 3 * p, phase_ff, inv_ff));
         end
      end
   end

   assign shared_out_1 = shared_ff[0];
   assign shared_out_2 = shared_ff[1];
   assign shared_out_3 = shared_ff[2];
   assign shared_out_4 = shared_ff[3];
   // Checks.
   sequence s_inhibit;
      !inh_s2_ff;
   endsequence
   sequence s_all_low;
      !common1_out && !common2_or_seg27 && !common3_or_seg26 && !common4_or_seg25
      && segment_mid_out == 20'h00000 && !extra_segment_out && shared_ff == 4'h0;
   endsequence
   property p_inhibit;
      @(posedge pclk) disable iff (!presetn) s_inhibit |=> s_all_low;
   endproperty
   a_inhibit: assert property (p_inhibit) else $error("Outputs not grounded under inhibit.");
   property p_extra_off;
      @(posedge pclk) disable iff (!presetn) !ext_en_ff |=> !extra_segment_out;
   endproperty
   a_extra_off: assert property (p_extra_off) else $error("Extra segment driven while off.");
   property p_quarter;
      @(posedge pclk) disable iff (!presetn)
      (on && is_quarter && phase_ff == 2'h3) |=> (common4_or_seg25 == !$past(inv_ff));
   endproperty
   a_quarter: assert property (p_quarter) else $error("Common four not selected.");
   property p_third;
      @(posedge pclk) disable iff (!presetn)
      (on && duty_ff == LCDSO_THIRD && phase_ff == 2'h0)
      |=> (common4_or_seg25 == ($past(disp_ff[72]) ^ $past(inv_ff)));
   endproperty
   a_third: assert property (p_third) else $error("Segment 25 data wrong.");
   property p_half;
      @(posedge pclk) disable iff (!presetn)
      (on && is_half && phase_ff == 2'h1)
      |=> (common3_or_seg26 == ($past(extra_seg_ff[4]) ^ $past(inv_ff)));
   endproperty
   a_half: assert property (p_half) else $error("Segment 26 data wrong.");
   property p_static;
      @(posedge pclk) disable iff (!presetn)
      (on && is_static && phase_ff == 2'h0)
      |=> (common2_or_seg27 == ($past(extra_seg_ff[0]) ^ $past(inv_ff)));
   endproperty
   a_static: assert property (p_static) else $error("Segment 27 data wrong.");
   property p_seg5;
      @(posedge pclk) disable iff (!presetn)
      (on && phase_ff == 2'h2) |=> (segment_mid_out[0] == ($past(disp_ff[14]) ^ $past(inv_ff)));
   endproperty
   a_seg5: assert property (p_seg5) else $error("Segment 5 data wrong.");
   property p_all_segments;
      @(posedge pclk) disable iff (!presetn)
      (on && port_sel_ff > 3'h4 && phase_ff == 2'h0)
      |=> (shared_out_4 == ($past(disp_ff[9]) ^ $past(inv_ff)));
   endproperty
   a_all_segments: assert property (p_all_segments) else $error("Pin 4 not a segment.");
   property p_level_port;
      @(posedge pclk) disable iff (!presetn)
      (on && port_sel_ff == 3'h1 && func_ff[1:0] == LCDSO_FN_LEVEL)
      |=> (shared_out_1 == $past(disp_ff[0]));
   endproperty
   a_level_port: assert property (p_level_port) else $error("Level port data wrong.");
   property p_clock_port;
      @(posedge pclk) disable iff (!presetn)
      (on && port_sel_ff == 3'h4 && func_ff[1:0] == LCDSO_FN_CLOCK)
      |=> (shared_out_1 == $past(clk_out_ff));
   endproperty
   a_clock_port: assert property (p_clock_port) else $error("Clock output missing.");
   property p_pwm_port;
      @(posedge pclk) disable iff (!presetn)
      (on && port_sel_ff == 3'h4 && func_ff[7:6] == 2'h3) |=> (shared_out_4 == $past(pwm[2]));
   endproperty
   a_pwm_port: assert property (p_pwm_port) else $error("Pulse width on pin 4 wrong.");
   property p_apply;
      @(posedge pclk) disable iff (!presetn)
      frame_new |=> (disp_ff == $past(frame_q[LCDSO_DISP_BITS-1:0]))
      && (func_ff == $past(frame_q[LCDSO_POS_FUNC +: 8]));
   endproperty
   a_apply: assert property (p_apply) else $error("Frame not applied whole.");
endmodule

// ### sim/lcdso_ctrl_model.sv
// Behavioural system controller that drives the three-wire serial link.
// Assumes the link clock idles low between frames and runs at 30 ns per bit.
`timescale 1ns/1ps
module lcdso_ctrl_model
   import lcdso_pkg::*;
(
   // Link pins.
   output logic serial_clock,
   output logic chip_enable,
   output logic serial_data_in
);
   initial begin
      serial_clock = 1'b0;
      chip_enable = 1'b0;
      serial_data_in = 1'b0;
   end
   // Sends one bit with a full link clock cycle.
   task automatic bit_out(input logic b);
      serial_data_in = b;
      #15 serial_clock = 1'b1;
      #15 serial_clock = 1'b0;
   endtask
   // address prefix
   // Address bits go out with enable low, then n data bits with enable high.
   task automatic send(input logic [7:0] addr, input logic [LCDSO_FRAME_BITS-1:0] bits,
      input int n);
      for (int i = 0; i < LCDSO_ADDR_BITS; i++) bit_out(addr[i]);
      chip_enable = 1'b1;
      for (int i = 0; i < n; i++) bit_out(bits[i]);
      chip_enable = 1'b0;
      serial_data_in = 1'b0;
   endtask
endmodule

// ### sim/lcdso_top_tb.sv
// Self-checking bench for the segment output block and a serial controller model.
// Assumes a 125 MHz bus clock and a link clock that stands still between frames.
`timescale 1ns/1ps
module lcdso_top_tb;
   import lcdso_pkg::*;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err, display_inhibit_n;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic serial_clock, chip_enable, serial_data_in, half_bias_out;
   logic common1_out, common2_or_seg27, common3_or_seg26, common4_or_seg25, extra_segment_out;
   logic shared_out_1, shared_out_2, shared_out_3, shared_out_4;
   logic [19:0] segment_mid_out;
   logic [9:0] ob, r;
   logic [77:0] pat;
   // Rows: duty code {hi,lo}, extra enable, port count code, expected port pin mask.
   logic [9:0] rows [8] = '{10'h000, 10'h191, 10'h223, 10'h3B7, 10'h0CF, 10'h150, 10'h2E0,
      10'h370};
   int bad_count, checks_done, frames, cnt [10];
   assign ob = {|segment_mid_out, common4_or_seg25, common3_or_seg26, common2_or_seg27,
      common1_out, extra_segment_out, shared_out_4, shared_out_3, shared_out_2, shared_out_1};
   lcdso_ctrl_model ctl_i(.serial_clock(serial_clock), .chip_enable(chip_enable),
      .serial_data_in(serial_data_in));
   lcdso_top lcdso_top_i(.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .serial_clock(serial_clock), .chip_enable(chip_enable),
      .serial_data_in(serial_data_in), .display_inhibit_n(display_inhibit_n),
      .common1_out(common1_out), .common2_or_seg27(common2_or_seg27),
      .common3_or_seg26(common3_or_seg26), .common4_or_seg25(common4_or_seg25),
      .segment_mid_out(segment_mid_out), .extra_segment_out(extra_segment_out),
      .shared_out_1(shared_out_1), .shared_out_2(shared_out_2), .shared_out_3(shared_out_3),
      .shared_out_4(shared_out_4), .half_bias_out(half_bias_out));
   task automatic summarize();
      if (bad_count == 0 && checks_done > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         bad_count++;
         $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // One bus transfer; the request holds until pready is sampled high.
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
      int n;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (pready !== 1'b1) begin
         bad_count++;
         summarize();
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   function automatic logic [109:0] mk(input logic [1:0] dt, input logic ex,
      input logic [2:0] ps, input logic [7:0] fn, input logic [17:0] w, input logic [77:0] d);
      mk = {w, fn, ps[0], ps[1], ps[2], ex, dt[1], dt[0], d};
   endfunction
   // Sends a frame and waits until the applied frame count moves on.
   task automatic send_cfg(input logic [109:0] f);
      int n;
      ctl_i.send(LCDSO_DEV_ADDR, f, LCDSO_FRAME_BITS);
      frames++;
      n = 0;
      do begin
         apb(1'b0, LCDSO_REG_STATUS, 32'h0);
         n++;
      end while (rd[15:8] !== frames[7:0] && n < 50);
      chk({24'h0, rd[15:8]}, {24'h0, frames[7:0]});
      repeat (2) @(posedge pclk);
   endtask
   // Counts the cycles in which each watched output is high.
   task automatic watch(input int n);
      for (int k = 0; k < 10; k++) cnt[k] = 0;
      repeat (n) begin
         @(negedge pclk);
         for (int k = 0; k < 10; k++) if (ob[k] === 1'b1) cnt[k]++;
      end
   endtask
   initial begin
      pclk = 1'b0;
      forever #4 pclk = ~pclk;
   end
   initial begin
      #400000;
      bad_count++;
      summarize();
   end
   initial begin
      {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
      display_inhibit_n = 1'b1;
      bad_count = 0;
      checks_done = 0;
      frames = 0;
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      apb(1'b0, LCDSO_REG_SCAN_DIV, 32'h0);
      chk(rd, 32'h0000_0400);
      apb(1'b0, LCDSO_REG_PWM_DIV, 32'h0);
      chk(rd, 32'h0000_0010);
      apb(1'b0, 8'h20, 32'h0);
      chk({31'h0, err}, 32'h1);
      chk(rd, 32'h0);
      apb(1'b1, LCDSO_REG_SCAN_DIV, 32'h4);
      apb(1'b1, LCDSO_REG_PWM_DIV, 32'h0);
      apb(1'b1, LCDSO_REG_STATUS, 32'hFFFF_FFFF);
      apb(1'b0, LCDSO_REG_SCAN_DIV, 32'h0);
      chk(rd, 32'h4);
      apb(1'b0, LCDSO_REG_STATUS, 32'h0);
      chk(rd & 32'hFF7F, 32'h40);
      for (int i = 0; i < 8; i++) begin
         r = rows[i];
         send_cfg(mk(r[9:8], r[7], r[6:4], 8'h00, 18'h0, 78'h0));
         chk(rd & 32'h3F, {26'h0, r[6:4], r[7], r[9:8]});
         watch(200);
         for (int k = 0; k < 4; k++) chk({31'h0, cnt[k] != 0}, {31'h0, !r[k]});
         chk({31'h0, cnt[4] != 0}, {31'h0, r[7]});
         chk({31'h0, half_bias_out}, {31'h0, r[9:8] == 2'b10});
      end
      send_cfg(mk(2'b00, 1'b0, 3'h4, 8'h00, 18'h0, 78'h249));
      watch(100);
      for (int k = 0; k < 4; k++) chk(cnt[k], 100);
      @(posedge pclk);
      display_inhibit_n <= 1'b0;
      repeat (3) @(posedge pclk);
      watch(50);
      for (int k = 0; k < 10; k++) chk(cnt[k], 0);
      @(posedge pclk);
      display_inhibit_n <= 1'b1;
      ctl_i.send(8'h45, mk(2'b11, 1'b1, 3'h1, 8'h00, 18'h0, 78'h0), LCDSO_FRAME_BITS);
      ctl_i.send(LCDSO_DEV_ADDR, mk(2'b11, 1'b1, 3'h1, 8'h00, 18'h0, 78'h0), 109);
      repeat (30) @(posedge pclk);
      apb(1'b0, LCDSO_REG_STATUS, 32'h0);
      chk(rd & 32'hFF7F, {16'h0, frames[7:0], 8'h60});
      pat = {14'h2A5C, 64'h1234_5678_9ABC_DEF0};
      send_cfg(mk(2'b00, 1'b0, 3'h4, 8'hE6, {6'h3F, 6'h32, 6'h1F}, pat));
      apb(1'b0, LCDSO_REG_DISP0, 32'h0);
      chk(rd, pat[31:0]);
      apb(1'b0, LCDSO_REG_DISP1, 32'h0);
      chk(rd, pat[63:32]);
      apb(1'b0, LCDSO_REG_DISP2, 32'h0);
      chk(rd, {18'h0, pat[77:64]});
      apb(1'b0, LCDSO_REG_PORT_CFG, 32'h0);
      chk(rd & 32'h03FF_FFFF, {6'h0, 6'h3F, 6'h32, 6'h1F, 8'hE6});
      watch(640);
      chk(cnt[0], 320);
      chk(cnt[1], 320);
      chk(cnt[2], 510);
      chk(cnt[3], 640);
      send_cfg(mk(2'b00, 1'b0, 3'h4, 8'h01, 18'h0, pat));
      watch(1300);
      chk(cnt[0], 650);
      @(posedge pclk);
      presetn <= 1'b0;
      repeat (2) @(posedge pclk);
      chk({22'h0, ob}, 32'h0);
      presetn <= 1'b1;
      apb(1'b0, LCDSO_REG_SCAN_DIV, 32'h0);
      chk(rd, 32'h0000_0400);
      apb(1'b0, LCDSO_REG_STATUS, 32'h0);
      chk(rd & 32'hFF7F, 32'h40);
      summarize();
   end
endmodule
